// *** include/serial_port_pkg.sv ***
// constants shared by the four-mode serial port: register addresses, field positions, modes, rates
// assumes a byte-wide special-register access port from the core
package serial_port_pkg;

  // ***************************************************************
  // register addresses and widths
  // ***************************************************************
  localparam int          ADDR_W          = 8;
  localparam logic [7:0]  ADDR_CONTROL    = 8'h98;
  localparam logic [7:0]  ADDR_DATA       = 8'h99;
  localparam logic [7:0]  CONTROL_RESET   = 8'h00;
  localparam logic [7:0]  DATA_RESET      = 8'h00;

  // ***************************************************************
  // control register field positions
  // ***************************************************************
  localparam int BIT_MODE_HI  = 7;
  localparam int BIT_MODE_LO  = 6;
  localparam int BIT_FILTER   = 5;
  localparam int BIT_RX_ALLOW = 4;
  localparam int BIT_TX_NINTH = 3;
  localparam int BIT_RX_NINTH = 2;
  localparam int BIT_TX_DONE  = 1;
  localparam int BIT_RX_DONE  = 0;

  // ***************************************************************
  // modes and rates
  // ***************************************************************
  typedef enum logic [1:0] {
    MODE_SHIFT = 2'b00,
    MODE_ASYNC8 = 2'b01,
    MODE_FIXED9 = 2'b10,
    MODE_VAR9 = 2'b11
  } serial_mode_t;

  localparam int OVERSAMPLE      = 16;  // samples per bit in async modes
  localparam int FIXED_DIV       = 64;  // core clocks per bit, fixed 9-bit mode
  localparam int T1_DIV          = 32;  // timer 1 overflows per bit
  localparam int T2_DIV          = 16;  // timer 2 overflows per bit
  localparam int SHIFT_HALF      = 6;   // core clocks per shift clock half period
  localparam int MID_SAMPLE      = 7;   // sample index at mid-bit
  localparam int TICK_CNT_W      = 6;
  localparam int FRAME8_BITS     = 10;
  localparam int FRAME9_BITS     = 11;
  localparam logic [3:0] DATA_BITS = 4'd8;

endpackage : serial_port_pkg

// *** rtl/serial_rate_gen.sv ***
// rate divider: makes a sixteen-times-oversample tick for one direction of the serial port
// assumes timer overflow inputs are one-cycle pulses synchronous to mclk_i
`timescale 1ns/10ps
`default_nettype none
module serial_rate_gen
  import serial_port_pkg::*;
(
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  input  wire logic fixed_rate_i,
  input  wire logic baud_double_i,
  input  wire logic timer2_select_i,
  input  wire logic timer1_ovf_i,
  input  wire logic timer2_ovf_i,
  output logic      sample_tick_o
);
  import serial_port_pkg::*;

  logic [TICK_CNT_W-1:0] cnt_q;
  logic [TICK_CNT_W-1:0] limit;
  logic                  src_pulse;

  // ***************************************************************
  // source selection and divider limit
  // ***************************************************************
  // oversample tick is bit rate x16, so the limits below are divisors over 16
  always_comb begin
    if (fixed_rate_i) begin
      src_pulse = 1'b1;
      limit     = TICK_CNT_W'((baud_double_i ? FIXED_DIV / 2 : FIXED_DIV) / OVERSAMPLE);
    end else if (timer2_select_i) begin
      src_pulse = timer2_ovf_i;
      limit     = TICK_CNT_W'(T2_DIV / OVERSAMPLE);
    end else begin
      src_pulse = timer1_ovf_i;
      limit     = TICK_CNT_W'((baud_double_i ? T1_DIV / 2 : T1_DIV) / OVERSAMPLE);
    end
  end

  // ***************************************************************
  // counter
  // ***************************************************************
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
    end else if (src_pulse) begin
      cnt_q <= (cnt_q + 1'b1 >= limit) ? '0 : cnt_q + 1'b1;
    end
  end

  assign sample_tick_o = src_pulse && (cnt_q + 1'b1 >= limit);

endmodule : serial_rate_gen
`default_nettype wire

// *** rtl/serial_port_four_mode.sv ***
// four-mode serial port: control/status and data registers, transmitter, receiver
// assumes a single-cycle special-register access from the core and timer overflow pulses
`timescale 1ns/10ps
`default_nettype none

// How it works
// - transmit and receive run together in async modes; shift-mode reception waits for transmit idle; a newer byte is dropped while receive-done is still set.
// - data writes load transmit shifter; data reads return separate receive register.
// - two mode bits pick shift, 8-bit, fixed 9-bit or variable 9-bit mode.
// - 8-bit mode with filter set keeps receive-done low on bad stop bit.
// - 9-bit modes with filter set drop frames whose ninth bit is zero.
// - reception only while receive-allow bit is set.
// - 9-bit modes send the transmit ninth-bit field as ninth bit.
// - receive ninth-bit field holds ninth bit, or stop bit in 8-bit mode.
// - transmit-done set after eighth bit (shift) or at stop start; hardware never clears.
// - receive-done set after eighth bit (shift) or mid stop bit; software clears.
// - shift mode moves eight bits LSB first on data line, clock on transmit line.
// - shift-mode reception starts when receive-allow is one and receive-done zero.
// - 8-bit frame: start zero, eight data LSB first, stop one.
// - 8-bit mode loads a one stop bit into ninth shifter position.
// - variable modes take timer 1 or timer 2 ticks, separately per direction.
// - async receiver starts on falling edge, checks start bit, skips it.
// - final shift stores byte, ninth bit, flag only if flag clear and filter passes.
// - fixed 9-bit rate is core clock over 64, or 32 when doubled.
// - 9-bit frame has start, eight data, ninth bit, stop: eleven bits.
// - 9-bit transmit loads ninth bit behind data, starts at next tick.
// - variable 9-bit mode equals fixed mode with timer-derived rate.
// - any data write starts transmit; async reception starts on start bit with allow.
// - timer 1 rate is overflows over 32, or 16 when doubled.
// - sixteen timer 2 overflows make one bit time.
// - per-direction select bits route timer 2 ticks; clear uses timer 1.
module serial_port_four_mode
  import serial_port_pkg::*;
(
  input  wire logic                        mclk_i,
  input  wire logic                        rst_n_i,
  input  wire logic [serial_port_pkg::ADDR_W-1:0] sfr_addr_i,
  input  wire logic                        sfr_wr_i,
  input  wire logic                        sfr_rd_i,
  input  wire logic [7:0]                  sfr_wdata_i,
  output logic      [7:0]                  sfr_rdata_o,
  input  wire logic                        baud_double_i,
  input  wire logic                        tx_timer2_select_i,
  input  wire logic                        rx_timer2_select_i,
  input  wire logic                        timer1_ovf_i,
  input  wire logic                        timer2_ovf_i,
  input  wire logic                        rxd_i,
  output logic                             rxd_o,
  output logic                             rxd_oe_o,
  output logic                             txd_o
);
  import serial_port_pkg::*;

  // ***************************************************************
  // declarations
  // ***************************************************************
  typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_SHIFT} tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_SHIFT} rx_state_t;

  serial_mode_t mode;
  logic       addr_filter_enable_q, rx_allow_q, tx_ninth_bit_q, rx_ninth_bit_q;
  logic       tx_done_flag_q, rx_done_flag_q;
  logic [1:0] mode_q;
  logic [7:0] rx_data_q;
  logic       wr_ctrl, wr_data, is_async;
  logic       tx_tick, rx_tick;

  tx_state_t  tx_state_q;
  logic [9:0] tx_shift_q;
  logic [3:0] tx_bits_q;
  logic [3:0] tx_phase_q;
  logic       txd_q, tx_set;

  rx_state_t  rx_state_q;
  logic [8:0] rx_shift_q;
  logic [3:0] rx_bits_q;
  logic [3:0] rx_phase_q;
  logic       rxd_prev_q, rx_set, rx_drop_last;
  logic [8:0] rx_final;

  logic [3:0] sh_div_q;
  logic       sh_clk_q, sh_rx_q, sh_edge_rise, sh_edge_fall;

  assign mode     = serial_mode_t'(mode_q);
  assign is_async = (mode != MODE_SHIFT);
  assign wr_ctrl  = sfr_wr_i && (sfr_addr_i == ADDR_CONTROL);
  assign wr_data  = sfr_wr_i && (sfr_addr_i == ADDR_DATA);

  function automatic logic tick_mid(input logic tick, input logic [3:0] phase);
    tick_mid = tick && (phase == 4'(MID_SAMPLE));
  endfunction : tick_mid

  // ***************************************************************
  // rate sources, one per direction so they may differ
  // ***************************************************************
  serial_rate_gen u_tx_rate (
    .mclk_i          (mclk_i),
    .rst_n_i         (rst_n_i),
    .fixed_rate_i    (mode == MODE_FIXED9),
    .baud_double_i   (baud_double_i),
    .timer2_select_i (tx_timer2_select_i),
    .timer1_ovf_i    (timer1_ovf_i),
    .timer2_ovf_i    (timer2_ovf_i),
    .sample_tick_o   (tx_tick)
  );

  serial_rate_gen u_rx_rate (
    .mclk_i          (mclk_i),
    .rst_n_i         (rst_n_i),
    .fixed_rate_i    (mode == MODE_FIXED9),
    .baud_double_i   (baud_double_i),
    .timer2_select_i (rx_timer2_select_i),
    .timer1_ovf_i    (timer1_ovf_i),
    .timer2_ovf_i    (timer2_ovf_i),
    .sample_tick_o   (rx_tick)
  );

  // ***************************************************************
  // control register
  // ***************************************************************
  // software bits plainly written
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      mode_q               <= CONTROL_RESET[BIT_MODE_HI:BIT_MODE_LO];
      addr_filter_enable_q <= CONTROL_RESET[BIT_FILTER];
      rx_allow_q           <= CONTROL_RESET[BIT_RX_ALLOW];
      tx_ninth_bit_q       <= CONTROL_RESET[BIT_TX_NINTH];
    end else if (wr_ctrl) begin
      mode_q               <= sfr_wdata_i[BIT_MODE_HI:BIT_MODE_LO];
      addr_filter_enable_q <= sfr_wdata_i[BIT_FILTER];
      rx_allow_q           <= sfr_wdata_i[BIT_RX_ALLOW];
      tx_ninth_bit_q       <= sfr_wdata_i[BIT_TX_NINTH];
    end
  end

  // done flags: a hardware set in the same cycle as a software write wins
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      tx_done_flag_q <= CONTROL_RESET[BIT_TX_DONE];
      rx_done_flag_q <= CONTROL_RESET[BIT_RX_DONE];
    end else begin
      if (tx_set)       tx_done_flag_q <= 1'b1;
      else if (wr_ctrl) tx_done_flag_q <= sfr_wdata_i[BIT_TX_DONE];
      if (rx_set)       rx_done_flag_q <= 1'b1;
      else if (wr_ctrl) rx_done_flag_q <= sfr_wdata_i[BIT_RX_DONE];
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    case (sfr_addr_i)
      ADDR_CONTROL: sfr_rdata_o = {mode_q, addr_filter_enable_q, rx_allow_q, tx_ninth_bit_q,
                                   rx_ninth_bit_q, tx_done_flag_q, rx_done_flag_q};
      ADDR_DATA:    sfr_rdata_o = rx_data_q;
      default:      sfr_rdata_o = 8'h00;
    endcase
  end

  // ***************************************************************
  // shift-mode clock: core clock over twelve
  // ***************************************************************
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || (tx_state_q != TX_SHIFT && rx_state_q != RX_SHIFT)) begin
      sh_div_q <= '0;
      sh_clk_q <= 1'b1;
    end else if (sh_div_q == 4'(SHIFT_HALF - 1)) begin
      sh_div_q <= '0;
      sh_clk_q <= ~sh_clk_q;
    end else begin
      sh_div_q <= sh_div_q + 4'd1;
    end
  end
  assign sh_edge_fall = (sh_div_q == 4'(SHIFT_HALF - 1)) && sh_clk_q;
  assign sh_edge_rise = (sh_div_q == 4'(SHIFT_HALF - 1)) && !sh_clk_q;

  // ***************************************************************
  // transmitter
  // ***************************************************************
  // a new write restarts the shifter even mid-frame; software is expected to wait
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      tx_state_q <= TX_IDLE;
      tx_shift_q <= '1;
      tx_bits_q  <= '0;
      tx_phase_q <= '0;
      txd_q      <= 1'b1;
    end else if (wr_data) begin
      // async: data then ninth/stop bit behind it, stop appended above
      tx_shift_q <= {1'b1, (mode == MODE_ASYNC8) ? 1'b1 : tx_ninth_bit_q, sfr_wdata_i};
      tx_bits_q  <= '0;
      tx_phase_q <= '0;
      tx_state_q <= is_async ? TX_WAIT : TX_SHIFT;
    end else begin
      case (tx_state_q)
        TX_IDLE: txd_q <= 1'b1;
        TX_WAIT: if (tx_tick) begin
          txd_q      <= 1'b0;  // start bit
          tx_state_q <= TX_SHIFT;
        end
        TX_SHIFT: if (!is_async) begin
          if (sh_edge_rise) begin
            tx_shift_q <= {1'b1, tx_shift_q[9:1]};
            tx_bits_q  <= tx_bits_q + 4'd1;
            if (tx_bits_q == DATA_BITS - 4'd1) tx_state_q <= TX_IDLE;
          end
        end else if (tx_tick) begin
          tx_phase_q <= tx_phase_q + 4'd1;
          if (tx_phase_q == 4'(OVERSAMPLE - 1)) begin
            txd_q      <= tx_shift_q[0];
            tx_shift_q <= {1'b1, tx_shift_q[9:1]};
            tx_bits_q  <= tx_bits_q + 4'd1;
            if (tx_bits_q == 4'((mode == MODE_ASYNC8) ? FRAME8_BITS - 1 : FRAME9_BITS - 1))
              tx_state_q <= TX_IDLE;
          end
        end
        default: tx_state_q <= TX_IDLE;
      endcase
    end
  end

  // transmit-done: end of eighth bit in shift mode, start of stop bit otherwise
  always_comb begin
    tx_set = 1'b0;
    if (tx_state_q == TX_SHIFT && !wr_data) begin
      if (!is_async)
        tx_set = sh_edge_rise && (tx_bits_q == DATA_BITS - 4'd1);
      else
        tx_set = tx_tick && (tx_phase_q == 4'(OVERSAMPLE - 1)) &&
                 (tx_bits_q == 4'((mode == MODE_ASYNC8) ? FRAME8_BITS - 2 : FRAME9_BITS - 2));
    end
  end

  // pins: shift mode drives data on receive line and clock on transmit line
  always_comb begin
    rxd_oe_o = (!is_async) && (tx_state_q == TX_SHIFT);  // line is an input while clocking data in
    rxd_o    = (tx_state_q == TX_SHIFT) ? tx_shift_q[0] : 1'b1;
    txd_o    = is_async ? txd_q : sh_clk_q;
  end

  // ***************************************************************
  // receiver
  // ***************************************************************
  // last bit seen: stop bit (8-bit) or ninth bit (9-bit) joins data
  assign rx_final = {rxd_i, rx_shift_q[8:1]};
  always_comb begin
    rx_drop_last = 1'b0;
    if (addr_filter_enable_q && mode == MODE_ASYNC8) rx_drop_last = !rxd_i;
    if (addr_filter_enable_q && mode[1])             rx_drop_last = !rx_shift_q[8];
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rxd_prev_q <= 1'b1;
    end else begin
      rxd_prev_q <= rxd_i;
    end
  end

  // shift mode: clock in on rising edge, eight bits
  // async: wait for falling edge, confirm mid-bit, sample each bit at mid-bit
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rx_state_q     <= RX_IDLE;
      rx_shift_q     <= '0;
      rx_bits_q      <= '0;
      rx_phase_q     <= '0;
      rx_data_q      <= DATA_RESET;
      rx_ninth_bit_q <= CONTROL_RESET[BIT_RX_NINTH];
      rx_set         <= 1'b0;
    end else begin
      rx_set <= 1'b0;
      if (wr_ctrl) rx_ninth_bit_q <= sfr_wdata_i[BIT_RX_NINTH];
      case (rx_state_q)
        RX_IDLE: begin
          rx_bits_q  <= '0;
          rx_phase_q <= '0;
          if (!is_async && rx_allow_q && !rx_done_flag_q && !rx_set && tx_state_q == TX_IDLE)
            rx_state_q <= RX_SHIFT;
          else if (is_async && rx_allow_q && rxd_prev_q && !rxd_i)
            rx_state_q <= RX_START;
        end
        RX_START: if (rx_tick) begin
          rx_phase_q <= rx_phase_q + 4'd1;
          if (tick_mid(rx_tick, rx_phase_q))
            rx_state_q <= rxd_i ? RX_IDLE : RX_DATA;
        end
        RX_DATA: if (rx_tick) begin
          rx_phase_q <= rx_phase_q + 4'd1;
          if (tick_mid(rx_tick, rx_phase_q)) begin
            rx_bits_q <= rx_bits_q + 4'd1;
            if (rx_bits_q == DATA_BITS + ((mode == MODE_ASYNC8) ? 4'd0 : 4'd1)) begin
              // mid stop bit: the final shift
              rx_state_q <= RX_IDLE;
              if (!rx_done_flag_q && !rx_drop_last) begin
                rx_data_q      <= (mode == MODE_ASYNC8) ? rx_shift_q[8:1] : rx_shift_q[7:0];
                rx_ninth_bit_q <= (mode == MODE_ASYNC8) ? rxd_i : rx_shift_q[8];
                rx_set         <= 1'b1;
              end
            end else begin
              rx_shift_q <= rx_final;
            end
          end
        end
        RX_SHIFT: if (sh_edge_rise) begin
          rx_shift_q <= rx_final;
          rx_bits_q  <= rx_bits_q + 4'd1;
          if (rx_bits_q == DATA_BITS - 4'd1) begin
            rx_state_q <= RX_IDLE;
            rx_data_q  <= rx_final[8:1];
            rx_set     <= 1'b1;
          end
        end
        default: rx_state_q <= RX_IDLE;
      endcase
      if (!rx_allow_q) rx_state_q <= RX_IDLE;
    end
  end

endmodule : serial_port_four_mode
`default_nettype wire

// *** bench/serial_port_four_mode_assertions.sv ***
// checker for the four-mode serial port, bound to its top module
// assumes the bench rests the register address on the control register
`timescale 1ns/10ps
`default_nettype none
module serial_port_four_mode_assertions
  import serial_port_pkg::*;
(
  input wire logic                                mclk_i,
  input wire logic                                rst_n_i,
  input wire logic [serial_port_pkg::ADDR_W-1:0] sfr_addr_i,
  input wire logic                                sfr_wr_i,
  input wire logic [7:0]                          sfr_wdata_i,
  input wire logic [7:0]                          sfr_rdata_o,
  input wire logic                                baud_double_i,
  input wire logic                                rxd_oe_o,
  input wire logic                                txd_o
);
  logic [1:0] mode_q;
  logic       allow_q;
  logic [9:0] low_q;
  // ********************
  // helper state
  // ********************
  // software copy of mode and allow fields
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      mode_q  <= 2'h0;
      allow_q <= 1'b0;
    end else if (sfr_wr_i && sfr_addr_i == ADDR_CONTROL) begin
      mode_q  <= sfr_wdata_i[7:6];
      allow_q <= sfr_wdata_i[BIT_RX_ALLOW];
    end
  end
  // low run length; frames are short, so no saturation
  always_ff @(posedge mclk_i) begin
    low_q <= (!rst_n_i || txd_o) ? 10'h000 : low_q + 10'h001;
  end
  // ********************
  // properties
  // ********************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // control seen on two edges with no write between: flags move by hardware only
  sequence s_view;
    sfr_addr_i == ADDR_CONTROL && $past(sfr_addr_i) == ADDR_CONTROL && !$past(sfr_wr_i) && $past(rst_n_i);
  endsequence
  property p_reset_idle;
    $rose(rst_n_i) |-> txd_o && !rxd_oe_o;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("line not idle after reset");
  property p_unmapped;
    (sfr_addr_i != ADDR_CONTROL && sfr_addr_i != ADDR_DATA) |-> sfr_rdata_o == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_oe_shift;
    rxd_oe_o |-> mode_q == MODE_SHIFT;
  endproperty
  a_oe_shift: assert property (p_oe_shift) else $error("data line driven outside shift mode");
  property p_tx_start;
    (sfr_wr_i && sfr_addr_i == ADDR_DATA && mode_q != MODE_SHIFT && txd_o) |-> ##[1:80] !txd_o;
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("no start bit after data write");
  property p_fixed_rate;
    ($rose(txd_o) && mode_q == MODE_FIXED9) |-> low_q != 0 && low_q % (baud_double_i ? 32 : 64) == 0;
  endproperty
  a_fixed_rate: assert property (p_fixed_rate) else $error("fixed rate bit length wrong");
  property p_tx_hold;
    s_view |-> !$fell(sfr_rdata_o[BIT_TX_DONE]);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("transmit done cleared by hardware");
  property p_rx_hold;
    s_view |-> !$fell(sfr_rdata_o[BIT_RX_DONE]);
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("receive done cleared by hardware");
  property p_sw_bits;
    s_view |-> $stable(sfr_rdata_o[7:3]);
  endproperty
  a_sw_bits: assert property (p_sw_bits) else $error("software fields changed alone");
  property p_rx_off;
    s_view ##0 !allow_q |-> !$rose(sfr_rdata_o[BIT_RX_DONE]);
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("receive done while disabled");
  c_fixed: cover property ($rose(txd_o) && mode_q == MODE_FIXED9);
  c_shift: cover property (rxd_oe_o);
  c_rx: cover property (s_view ##0 $rose(sfr_rdata_o[BIT_RX_DONE]));
endmodule : serial_port_four_mode_assertions
bind serial_port_four_mode serial_port_four_mode_assertions u_chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
  .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
  .baud_double_i(baud_double_i), .rxd_oe_o(rxd_oe_o), .txd_o(txd_o));
`default_nettype wire

// *** bench/serial_remote_node.sv ***
// remote serial node: sends frames into the port and captures what it sends
// assumes bit_i core clocks per bit; shift clock arrives on txd in shift mode
`timescale 1ns/10ps
`default_nettype none
module serial_remote_node (
  input  wire logic        mclk_i,
  input  wire logic        txd_i,
  input  wire logic        dat_i,
  input  wire logic        shift_i,
  input  wire logic [6:0]  bit_i,
  input  wire logic [3:0]  nbits_i,
  output logic             rxd_o,
  output logic      [10:0] got_o
);
  event got_ev;
  int   i;
  // ********************
  // frame driver and capture
  // ********************
  initial rxd_o = 1'b1;
  // start bit first, one bit per bit_i clocks
  task automatic send(input logic [10:0] f);
    for (int k = 0; k < nbits_i; k++) begin
      rxd_o = f[k];
      repeat (bit_i) @(negedge mclk_i);
    end
    rxd_o = 1'b1; // line driven back to its idle one
  endtask : send
  // shift data is stable at the falling clock; async sampled mid-bit
  always begin
    @(negedge txd_i);
    got_o = 11'h000;
    if (shift_i) begin
      got_o[0] = dat_i;
      for (i = 1; i < 8; i++) begin
        @(negedge txd_i);
        got_o[i] = dat_i;
      end
    end else begin
      repeat (bit_i / 2) @(posedge mclk_i);
      for (i = 0; i < nbits_i; i++) begin
        got_o[i] = txd_i;
        repeat (bit_i) @(posedge mclk_i);
      end
    end
    -> got_ev;
  end
endmodule : serial_remote_node
`default_nettype wire

// *** bench/serial_port_four_mode_tb.sv ***
// testbench for the four-mode serial port with a remote node on its lines
// assumes timers overflow every 2 (timer 1) and 4 (timer 2) clocks
`timescale 1ns/10ps
`default_nettype none
module serial_port_four_mode_tb;
  import serial_port_pkg::*;
  logic              mclk_i, rst_n_i, sfr_wr_i, sfr_rd_i, baud_double_i, timer1_ovf_i, timer2_ovf_i;
  logic              tx_timer2_select_i, rx_timer2_select_i, rxd_o, rxd_oe_o, txd_o, node_rxd, shift_mode;
  logic [ADDR_W-1:0] sfr_addr_i;
  logic [7:0]        sfr_wdata_i, sfr_rdata_o, rx_exp, d, rb;
  logic [6:0]        bit_len;
  logic [3:0]        nbits;
  logic [1:0]        tcnt = 2'h0;
  logic [10:0]       frm, notes[$];
  logic              rb8_exp, flag_exp, tb8, ok;
  // rows: baud double, mode, filter, allow, ninth in, keep flag, tx sel, rx sel
  logic [8:0]        rows [0:6] = '{9'h058, 9'h072, 9'h0B0, 9'h0FB, 9'h0D7, 9'h190, 9'h048};
  int                miscompares, checks_done, seed, r, k;
  wire               rxd_line = rxd_oe_o ? rxd_o : node_rxd;
  serial_port_four_mode DUT (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
    .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .baud_double_i(baud_double_i),
    .tx_timer2_select_i(tx_timer2_select_i), .rx_timer2_select_i(rx_timer2_select_i),
    .timer1_ovf_i(timer1_ovf_i), .timer2_ovf_i(timer2_ovf_i), .rxd_i(rxd_line), .rxd_o(rxd_o),
    .rxd_oe_o(rxd_oe_o), .txd_o(txd_o));
  serial_remote_node node (.mclk_i(mclk_i), .txd_i(txd_o), .dat_i(rxd_line), .shift_i(shift_mode),
    .bit_i(bit_len), .nbits_i(nbits), .rxd_o(node_rxd), .got_o());
  // ********************
  // clock, timers, tasks
  // ********************
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  // overflow pulses stand in for the timers
  always @(negedge mclk_i) begin
    tcnt         <= tcnt + 2'h1;
    timer1_ovf_i <= tcnt[0];
    timer2_ovf_i <= &tcnt;
  end
  task automatic check(input string name, input logic [10:0] seen, input logic [10:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out
  // address rests on control so flag watching stays meaningful
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    sfr_addr_i  = a;
    sfr_wdata_i = v;
    sfr_wr_i    = 1'b1;
    @(negedge mclk_i);
    sfr_wr_i    = 1'b0;
    sfr_addr_i  = ADDR_CONTROL;
    @(negedge mclk_i); // let an edge pass before the next request
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    sfr_addr_i = a;
    sfr_rd_i   = 1'b1;
    @(posedge mclk_i);
    check("read", {3'h0, sfr_rdata_o}, {3'h0, e});
    @(negedge mclk_i);
    sfr_rd_i   = 1'b0;
    sfr_addr_i = ADDR_CONTROL;
    @(negedge mclk_i); // let an edge pass before the next request
  endtask : rd
  task automatic wait_empty;
    for (k = 0; k < 3000 && notes.size() != 0; k++) @(negedge mclk_i);
    if (notes.size() != 0) begin
      miscompares++;
      close_out();
    end
  endtask : wait_empty
  // oldest note against each captured frame
  always @(node.got_ev) begin
    if (notes.size() == 0) check("stray frame", node.got_o, 11'h7FF);
    else check("frame", node.got_o, notes.pop_front());
  end
  // ********************
  // main sequence
  // ********************
  initial begin
    seed = 32'h47DD;
    {rst_n_i, sfr_wr_i, sfr_rd_i, baud_double_i, tx_timer2_select_i, rx_timer2_select_i} = 6'h00;
    {shift_mode, rb8_exp, sfr_wdata_i, sfr_addr_i} = {2'h0, 8'h00, ADDR_CONTROL};
    {bit_len, nbits, rx_exp} = {7'h40, 4'hA, DATA_RESET};
    repeat (6) @(negedge mclk_i);
    rst_n_i = 1'b1;
    rd(ADDR_CONTROL, CONTROL_RESET);
    rd(ADDR_DATA, DATA_RESET);
    rd(8'h97, 8'h00);
    $display("reset test done");
    for (r = 0; r < 7; r++) begin
      {baud_double_i, tx_timer2_select_i, rx_timer2_select_i} = {rows[r][8], rows[r][1:0]};
      bit_len = rows[r][8] ? 7'h20 : 7'h40;
      nbits   = (rows[r][7:6] == MODE_ASYNC8) ? 4'hA : 4'hB;
      tb8     = $random(seed);
      d       = $random(seed);
      rb      = $random(seed);
      wr(ADDR_CONTROL, {rows[r][7:4], tb8, rb8_exp, 1'b0, rows[r][2]});
      notes.push_back(nbits == 4'hA ? {2'b01, d, 1'b0} : {1'b1, tb8, d, 1'b0});
      frm = nbits == 4'hA ? {2'b00, rows[r][3], rb, 1'b0} : {1'b1, rows[r][3], rb, 1'b0};
      ok  = rows[r][4] && !rows[r][2] && (!rows[r][5] || rows[r][3]);
      flag_exp = ok || rows[r][2];
      if (ok) {rx_exp, rb8_exp} = {rb, rows[r][3]};
      fork
        wr(ADDR_DATA, d);
        node.send(frm);
      join
      wait_empty();
      rd(ADDR_CONTROL, {rows[r][7:4], tb8, rb8_exp, 1'b1, flag_exp});
      rd(ADDR_DATA, rx_exp);
      $display("row %0d test done", r);
    end
    shift_mode = 1'b1;
    wr(ADDR_CONTROL, 8'h00);
    d = $random(seed);
    notes.push_back({3'h0, d});
    wr(ADDR_DATA, d);
    wait_empty();
    repeat (8) @(negedge mclk_i); // transmit-done comes on the eighth rising clock, after the last fall
    rd(ADDR_CONTROL, 8'h02);
    // receive: one idle bit leads, since the first rising clock comes a bit period in
    d = $random(seed);
    {bit_len, nbits} = {7'(2 * SHIFT_HALF), 4'h9};
    notes.push_back({3'h0, d[6:0], 1'b1});
    fork
      wr(ADDR_CONTROL, 8'h10);
      node.send({2'h0, d, 1'b1});
    join
    wait_empty();
    rd(ADDR_CONTROL, 8'h11);
    rd(ADDR_DATA, d);
    $display("shift test done");
    close_out();
  end
endmodule : serial_port_four_mode_tb
`default_nettype wire
